// >>> sdi_defines.svh
`ifndef SDI_DEFINES_SVH
`define SDI_DEFINES_SVH

// Register byte offsets
`define SDI_CTRL_OFS 8'h00
`define SDI_STATUS_OFS 8'h04
`define SDI_RESULT_OFS 8'h08
`define SDI_IRQ_STATUS_OFS 8'h0c
`define SDI_IRQ_MASK_OFS 8'h10

// Control field positions
`define SDI_CTRL_TRIG_LSB 0
`define SDI_CTRL_FRC_BIT 2
`define SDI_CTRL_FIFO_EN_BIT 3
`define SDI_CTRL_SRGM_LSB 4
`define SDI_CTRL_LVL_LSB 6
`define SDI_CTRL_SW_WIN_BIT 8
`define SDI_CTRL_W 9
`define SDI_CTRL_RESET 9'h000

// Trigger and request encodings
`define SDI_TRIG_SW 2'h0
`define SDI_TRIG_RISE 2'h1
`define SDI_TRIG_FALL 2'h2
`define SDI_SRGM_OFF 2'h0
`define SDI_SRGM_ALL 2'h3

// Interrupt status bits
`define SDI_IRQ_W 3
`define SDI_IRQ_RESULT_BIT 0
`define SDI_IRQ_WERR_BIT 1
`define SDI_IRQ_DONE_BIT 2

`define SDI_RESP_OKAY 2'h0
`define SDI_RESP_SLVERR 2'h2

`endif

// >>> sdi_pkg.sv
package sdi_pkg;

  typedef enum logic {WIN_IDLE, WIN_OPEN} win_state_t;

endpackage : sdi_pkg

// >>> sdi_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sdi_pin_sync (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic pin_in,
  output logic level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once two late stages agree
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_out = level_q;

endmodule : sdi_pin_sync

`default_nettype wire

// >>> sdi_result_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sdi_result_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  input wire logic push_valid_in,
  output logic push_ready_out,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  output logic pop_valid_out,
  output logic [WIDTH-1:0] head_out,
  output logic [CNT_W-1:0] count_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CNT_W-1:0] count_q;
  logic do_push;
  logic do_pop;

  assign push_ready_out = (count_q != CNT_W'(DEPTH));
  assign pop_valid_out = (count_q != '0);
  assign do_push = push_valid_in && push_ready_out;
  assign do_pop = pop_in && pop_valid_out;

  // Shift register: stage 0 is the oldest entry
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (do_pop && i < DEPTH - 1 && CNT_W'(i + 1) < count_q) begin
          mem_q[i] <= mem_q[i + 1];
        end
        if (do_push && CNT_W'(i) == count_q - CNT_W'(do_pop)) begin
          mem_q[i] <= push_data_in;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= '0;
    end else if (flush_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  assign head_out = mem_q[0];
  assign count_out = count_q;

endmodule : sdi_result_fifo

`default_nettype wire

// >>> sigma_delta_integration_result.sv
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sdi_defines.svh"

// Behaviour
// - Trigger modes 01 and 10 mean hardware window
// - Hardware window start clears chain unless reset control
// - Same start also clears auxiliary CIC stage
// - Reset control set: only the FIFO is cleared
// - Window accumulates samples in integrator until window end
// - Integrator idle: result comes from chain
// - No FIFO: each chain result overwrites
// - FIFO keeps result until read or next hardware window start
// - Paired modes: requests only inside window
// - Idle chain results still enter FIFO
// - Full FIFO discards and flags write error
module sigma_delta_integration_result #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic trigger_in,
  input wire logic sample_valid_in,
  input wire logic [DATA_W-1:0] sample_data_in,
  output logic chain_clear_out,
  output logic aux_clear_out,
  output logic result_request_out,
  output logic irq_out
);

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  logic aw_hold_q;
  logic w_hold_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;

  logic [`SDI_CTRL_W-1:0] ctrl_q;
  logic [`SDI_IRQ_W-1:0] irq_status_q;
  logic [`SDI_IRQ_W-1:0] irq_mask_q;
  logic [`SDI_IRQ_W-1:0] irq_set;
  logic [`SDI_IRQ_W-1:0] irq_clr;

  logic [1:0] trig_mode;
  logic frc;
  logic fifo_en;
  logic [1:0] srgm;
  logic [1:0] req_level;
  logic hw_mode;
  logic trig_lvl;
  logic trig_prev_q;
  logic sw_prev_q;
  logic start_evt;
  logic end_evt;
  sdi_pkg::win_state_t win_q;
  logic active;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_base;
  logic [DATA_W-1:0] result_q;

  logic push_valid;
  logic push_window;
  logic [DATA_W-1:0] push_data;
  logic fifo_ready;
  logic fifo_avail;
  logic [DATA_W-1:0] fifo_head;
  logic [CNT_W-1:0] fifo_count;
  logic fifo_push;
  logic fifo_pop;
  logic push_taken;
  logic sr_event;

  assign trig_mode = ctrl_q[`SDI_CTRL_TRIG_LSB +: 2];
  assign frc = ctrl_q[`SDI_CTRL_FRC_BIT];
  assign fifo_en = ctrl_q[`SDI_CTRL_FIFO_EN_BIT];
  assign srgm = ctrl_q[`SDI_CTRL_SRGM_LSB +: 2];
  assign req_level = ctrl_q[`SDI_CTRL_LVL_LSB +: 2];

  // Register bus: one write and one read at a time
  assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_out = !w_hold_q && !bvalid_q;
  assign s_axi_arready_out = !rvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `SDI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      unique case (awaddr_q)
        `SDI_CTRL_OFS, `SDI_IRQ_STATUS_OFS, `SDI_IRQ_MASK_OFS:
          bresp_q <= `SDI_RESP_OKAY;
        default:
          bresp_q <= `SDI_RESP_SLVERR;
      endcase
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= `SDI_CTRL_RESET;
      irq_mask_q <= '0;
    end else if (wr_fire) begin
      if (awaddr_q == `SDI_CTRL_OFS) begin
        ctrl_q <= (ctrl_q & ~wmask[`SDI_CTRL_W-1:0])
                  | (wdata_q[`SDI_CTRL_W-1:0] & wmask[`SDI_CTRL_W-1:0]);
      end
      if (awaddr_q == `SDI_IRQ_MASK_OFS) begin
        irq_mask_q <= (irq_mask_q & ~wmask[`SDI_IRQ_W-1:0])
                      | (wdata_q[`SDI_IRQ_W-1:0] & wmask[`SDI_IRQ_W-1:0]);
      end
    end
  end

  // Result reads pop the FIFO so the next entry moves up
  assign fifo_pop = rd_fire && fifo_en
                    && s_axi_araddr_in == `SDI_RESULT_OFS;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_q <= 1'b0;
      rresp_q <= `SDI_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= `SDI_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (s_axi_araddr_in)
        `SDI_CTRL_OFS:
          rdata_q[`SDI_CTRL_W-1:0] <= ctrl_q;
        `SDI_STATUS_OFS:
          rdata_q <= {24'h000000, 4'(fifo_count), 1'b0, fifo_avail,
                      irq_status_q[`SDI_IRQ_WERR_BIT], active};
        `SDI_RESULT_OFS:
          rdata_q <= 32'(fifo_en ? fifo_head : result_q);
        `SDI_IRQ_STATUS_OFS:
          rdata_q[`SDI_IRQ_W-1:0] <= irq_status_q;
        `SDI_IRQ_MASK_OFS:
          rdata_q[`SDI_IRQ_W-1:0] <= irq_mask_q;
        default:
          rresp_q <= `SDI_RESP_SLVERR;
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;

  // Window control
  sdi_pin_sync u_trig_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(trigger_in),
    .level_out(trig_lvl)
  );

  assign hw_mode = trig_mode == `SDI_TRIG_RISE
                   || trig_mode == `SDI_TRIG_FALL;
  assign active = (win_q == sdi_pkg::WIN_OPEN);

  always_comb begin
    start_evt = 1'b0;
    end_evt = 1'b0;
    unique case (trig_mode)
      `SDI_TRIG_RISE: begin
        start_evt = !active && trig_lvl && !trig_prev_q;
        end_evt = active && !trig_lvl && trig_prev_q;
      end
      `SDI_TRIG_FALL: begin
        start_evt = !active && !trig_lvl && trig_prev_q;
        end_evt = active && trig_lvl && !trig_prev_q;
      end
      `SDI_TRIG_SW: begin
        start_evt = !active && ctrl_q[`SDI_CTRL_SW_WIN_BIT] && !sw_prev_q;
        end_evt = active && !ctrl_q[`SDI_CTRL_SW_WIN_BIT];
      end
      default: begin
        end_evt = active;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_prev_q <= 1'b0;
      sw_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_lvl;
      sw_prev_q <= ctrl_q[`SDI_CTRL_SW_WIN_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      win_q <= sdi_pkg::WIN_IDLE;
    end else if (start_evt) begin
      win_q <= sdi_pkg::WIN_OPEN;
    end else if (end_evt) begin
      win_q <= sdi_pkg::WIN_IDLE;
    end
  end

  // Clear pulses leave in the start cycle, ahead of the next sample
  assign chain_clear_out = start_evt && hw_mode && !frc;
  assign aux_clear_out = chain_clear_out;
  assign acc_base = chain_clear_out ? '0 : acc_q;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= '0;
    end else if (start_evt || (active && !end_evt)) begin
      acc_q <= acc_base
               + (sample_valid_in ? sample_data_in : '0);
    end
  end

  // Result source: integrator at window end, chain while idle
  always_comb begin
    push_valid = 1'b0;
    push_window = 1'b0;
    push_data = sample_data_in;
    if (end_evt) begin
      push_valid = 1'b1;
      push_window = 1'b1;
      push_data = acc_q;
    end else if (!active && !start_evt && sample_valid_in) begin
      push_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_q <= '0;
    end else if (push_valid && !fifo_en) begin
      result_q <= push_data;
    end
  end

  assign fifo_push = push_valid && fifo_en;
  assign push_taken = push_valid && (!fifo_en || fifo_ready);

  sdi_result_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .CNT_W(CNT_W)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .flush_in(start_evt && hw_mode && fifo_en),
    .push_valid_in(fifo_push),
    .push_ready_out(fifo_ready),
    .push_data_in(push_data),
    .pop_in(fifo_pop),
    .pop_valid_out(fifo_avail),
    .head_out(fifo_head),
    .count_out(fifo_count)
  );

  // Modes 01 and 10 only signal results made inside the window
  always_comb begin
    sr_event = 1'b0;
    if (push_taken && fifo_count >= CNT_W'(req_level)) begin
      unique case (srgm)
        `SDI_SRGM_OFF: sr_event = 1'b0;
        `SDI_SRGM_ALL: sr_event = 1'b1;
        default: sr_event = push_window;
      endcase
    end
  end

  assign result_request_out = sr_event;

  assign irq_set = {end_evt, fifo_push && !fifo_ready, sr_event};
  assign irq_clr = (wr_fire && awaddr_q == `SDI_IRQ_STATUS_OFS)
                   ? (wdata_q[`SDI_IRQ_W-1:0] & wmask[`SDI_IRQ_W-1:0]) : '0;

  // Set beats a simultaneous write-one-to-clear
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  assign irq_out = |(irq_status_q & irq_mask_q);

  sequence s_hw_start;
    start_evt && hw_mode && !frc;
  endsequence

  sequence s_idle_sample;
    !active && !start_evt && !end_evt && sample_valid_in;
  endsequence

  a_mode_gates_clear: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) chain_clear_out |-> hw_mode)
    else $error("clear pulse outside hardware trigger mode");

  a_chain_clear_start: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    s_hw_start and !sample_valid_in |-> chain_clear_out ##1 acc_q == '0)
    else $error("window start did not clear the integrator");

  a_aux_with_chain: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) chain_clear_out == aux_clear_out)
    else $error("auxiliary clear not paired with chain clear");

  a_frc_keeps_state: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    start_evt && frc && !sample_valid_in |=> acc_q == $past(acc_q)
      && !$past(aux_clear_out))
    else $error("filter cleared although reset control is set");

  a_acc_sums: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    active && !end_evt && sample_valid_in
      |=> acc_q == $past(acc_q) + $past(sample_data_in))
    else $error("integrator missed a sample");

  a_idle_overwrite: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    s_idle_sample and !fifo_en |=> result_q == $past(sample_data_in))
    else $error("idle chain result not in result register");

  a_fifo_holds: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    fifo_en && fifo_avail && !fifo_pop && !start_evt
      |=> fifo_head == $past(fifo_head))
    else $error("held result changed without a read");

  a_idle_no_request: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    result_request_out && srgm != `SDI_SRGM_ALL |-> end_evt)
    else $error("service request outside the window");

  a_idle_stored: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    s_idle_sample and fifo_en && fifo_ready && !fifo_pop
      |=> fifo_count == $past(fifo_count) + 1'b1)
    else $error("idle result not stored in the fifo");

  a_full_error: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in)
    fifo_push && !fifo_ready && !fifo_pop
      |=> irq_status_q[`SDI_IRQ_WERR_BIT]
      && fifo_count == $past(fifo_count))
    else $error("full fifo did not flag write error");

endmodule : sigma_delta_integration_result

`default_nettype wire

// >>> sdi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdi_host_model (
  input wire logic core_clk_in,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out,
  input wire logic request_in
);
  int n_requests = 0;

  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
    {awaddr_out, araddr_out, wstrb_out, wdata_out} = '0;
  end

  always @(posedge core_clk_in) begin
    if (request_in === 1'b1) n_requests <= n_requests + 1;
  end

  // Each channel is judged at the rising edge where both sides see it
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    logic pa, pw, pb;
    @(posedge core_clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    while (pb) begin
      @(posedge core_clk_in);
      if (pa && awready_in) begin
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
        pa = 1'b0;
      end
      if (pw && wready_in) begin
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
        pw = 1'b0;
      end
      if (bvalid_in) begin
        resp = bresp_in;
        bready_out <= 1'b0;
        pb = 1'b0;
      end
    end
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    logic pa, pr;
    @(posedge core_clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    while (pr) begin
      @(posedge core_clk_in);
      if (pa && arready_in) begin
        arvalid_out <= 1'b0;
        araddr_out <= ~a;
        pa = 1'b0;
      end
      if (rvalid_in) begin
        d = rdata_in;
        resp = rresp_in;
        rready_out <= 1'b0;
        pr = 1'b0;
      end
    end
  endtask : read_reg
endmodule : sdi_host_model

`default_nettype wire

// >>> test_sigma_delta_integration_result.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdi_defines.svh"

module test_sigma_delta_integration_result;
  logic core_clk_in, reset_n_in, trigger_in, sample_valid_in;
  logic [31:0] sample_data_in, s_axi_wdata_in, s_axi_rdata_out, rd;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic s_axi_rready_in, chain_clear_out, aux_clear_out;
  logic result_request_out, irq_out;
  int n_errors = 0;
  int comparisons = 0;
  int n_clears = 0;

  sigma_delta_integration_result #(.DATA_W(32), .FIFO_DEPTH(4)) i_dut (
    .core_clk_in, .reset_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .trigger_in,
    .sample_valid_in, .sample_data_in, .chain_clear_out, .aux_clear_out,
    .result_request_out, .irq_out
  );

  sdi_host_model i_host (
    .core_clk_in, .awaddr_out(s_axi_awaddr_in), .awvalid_out(s_axi_awvalid_in),
    .awready_in(s_axi_awready_out), .wdata_out(s_axi_wdata_in),
    .wstrb_out(s_axi_wstrb_in), .wvalid_out(s_axi_wvalid_in),
    .wready_in(s_axi_wready_out), .bresp_in(s_axi_bresp_out),
    .bvalid_in(s_axi_bvalid_out), .bready_out(s_axi_bready_in),
    .araddr_out(s_axi_araddr_in), .arvalid_out(s_axi_arvalid_in),
    .arready_in(s_axi_arready_out), .rdata_in(s_axi_rdata_out),
    .rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out),
    .rready_out(s_axi_rready_in), .request_in(result_request_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  always @(posedge core_clk_in) begin
    if (chain_clear_out === 1'b1) n_clears <= n_clears + 1;
    if (chain_clear_out !== 1'b0 || aux_clear_out !== 1'b0) begin
      check({31'h0, aux_clear_out}, {31'h0, chain_clear_out});
    end
  end

  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    i_host.read_reg(a, rd, rsp);
    check(rd, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.write_reg(a, d, rsp);
  endtask : wr

  task automatic sample(input logic [31:0] d);
    @(posedge core_clk_in);
    sample_valid_in <= 1'b1;
    sample_data_in <= d;
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
    sample_data_in <= ~d;
  endtask : sample

  // Long enough for the pin synchroniser and the window edge logic
  task automatic trig(input logic lvl);
    @(posedge core_clk_in);
    trigger_in <= lvl;
    cyc(8);
  endtask : trig

  task automatic t_regs;
    rd_chk(`SDI_CTRL_OFS, 32'h0);
    rd_chk(`SDI_STATUS_OFS, 32'h0);
    rd_chk(`SDI_IRQ_STATUS_OFS, 32'h0);
    rd_chk(`SDI_IRQ_MASK_OFS, 32'h0);
    rd_chk(8'h14, 32'h0);
    check({30'h0, rsp}, {30'h0, `SDI_RESP_SLVERR});
    wr(8'h20, 32'hffff_ffff);
    check({30'h0, rsp}, {30'h0, `SDI_RESP_SLVERR});
    wr(`SDI_STATUS_OFS, 32'hff);
    rd_chk(`SDI_STATUS_OFS, 32'h0);
    wr(`SDI_IRQ_MASK_OFS, 32'hffff_ffff);
    rd_chk(`SDI_IRQ_MASK_OFS, 32'h7);
    wr(`SDI_IRQ_MASK_OFS, 32'h1 << `SDI_IRQ_DONE_BIT);
  endtask : t_regs

  task automatic t_modes;
    int c;
    for (int m = 0; m < 4; m += 3) begin
      wr(`SDI_CTRL_OFS, 32'(m));
      c = n_clears;
      trig(1'b1);
      trig(1'b0);
      check(32'(n_clears), 32'(c));
    end
    trig(1'b1);
    wr(`SDI_CTRL_OFS, {30'h0, `SDI_TRIG_FALL});
    c = n_clears;
    trig(1'b0);
    check(32'(n_clears), 32'(c + 1));
    trig(1'b1);
  endtask : t_modes

  task automatic t_plain;
    int c;
    wr(`SDI_IRQ_STATUS_OFS, 32'h7);
    check({31'h0, irq_out}, 32'h0);
    wr(`SDI_CTRL_OFS, {30'h0, `SDI_TRIG_RISE});
    // Pin is still high from the last scenario: drop it while idle
    trig(1'b0);
    c = n_clears;
    trig(1'b1);
    check(32'(n_clears), 32'(c + 1));
    sample(32'h1);
    sample(32'h2);
    sample(32'h3);
    rd_chk(`SDI_STATUS_OFS, 32'h1);
    trig(1'b0);
    rd_chk(`SDI_RESULT_OFS, 32'h6);
    rd_chk(`SDI_STATUS_OFS, 32'h0);
    check({31'h0, irq_out}, 32'h1);
    sample(32'h55);
    rd_chk(`SDI_RESULT_OFS, 32'h55);
    sample(32'h66);
    rd_chk(`SDI_RESULT_OFS, 32'h66);
    wr(`SDI_IRQ_STATUS_OFS, 32'h4);
    check({31'h0, irq_out}, 32'h0);
  endtask : t_plain

  task automatic t_keep;
    int c;
    wr(`SDI_CTRL_OFS, 32'h1 | (32'h1 << `SDI_CTRL_FRC_BIT));
    c = n_clears;
    trig(1'b1);
    trig(1'b0);
    check(32'(n_clears), 32'(c));
    // Integrator kept its old sum, so the result is still six
    rd_chk(`SDI_RESULT_OFS, 32'h6);
  endtask : t_keep

  task automatic t_fifo;
    int c;
    wr(`SDI_CTRL_OFS, 32'h1 | (32'h1 << `SDI_CTRL_FIFO_EN_BIT) |
       (32'h2 << `SDI_CTRL_SRGM_LSB));
    c = i_host.n_requests;
    sample(32'h11);
    // Request counter updates on the edge that the sample returns at
    cyc(1);
    check(32'(i_host.n_requests), 32'(c));
    trig(1'b1);
    sample(32'h5);
    sample(32'h6);
    trig(1'b0);
    check(32'(i_host.n_requests), 32'(c + 1));
    for (int i = 1; i < 4; i++) sample(32'h20 + 32'(i));
    cyc(1);
    check(32'(i_host.n_requests), 32'(c + 1));
    rd_chk(`SDI_STATUS_OFS, 32'h44);
    sample(32'h24);
    rd_chk(`SDI_STATUS_OFS, 32'h46);
    rd_chk(`SDI_RESULT_OFS, 32'hb);
    for (int i = 1; i < 4; i++) begin
      rd_chk(`SDI_RESULT_OFS, 32'h20 + 32'(i));
    end
    rd_chk(`SDI_STATUS_OFS, 32'h2);
    // Window end also left the service request bit set
    rd_chk(`SDI_IRQ_STATUS_OFS, 32'h7);
    wr(`SDI_IRQ_STATUS_OFS, 32'h4);
    check({31'h0, irq_out}, 32'h0);
    rd_chk(`SDI_IRQ_STATUS_OFS, 32'h3);
    wr(`SDI_IRQ_STATUS_OFS, 32'h3);
    rd_chk(`SDI_IRQ_STATUS_OFS, 32'h0);
    // Request on every result, idle ones included
    wr(`SDI_CTRL_OFS, 32'h1 | (32'h1 << `SDI_CTRL_FIFO_EN_BIT) |
       (32'h3 << `SDI_CTRL_SRGM_LSB));
    c = i_host.n_requests;
    sample(32'h31);
    cyc(1);
    check(32'(i_host.n_requests), 32'(c + 1));
  endtask : t_fifo

  initial begin
    reset_n_in = 1'b0;
    trigger_in = 1'b0;
    sample_valid_in = 1'b0;
    sample_data_in = '0;
    cyc(8);
    reset_n_in <= 1'b1;
    t_regs;
    t_modes;
    t_plain;
    t_keep;
    t_fifo;
    results;
  end

  // The whole sequence needs about three hundred cycles
  initial begin
    cyc(20000);
    n_errors++;
    results;
  end
endmodule : test_sigma_delta_integration_result

`default_nettype wire
